// file: core/pm_i2c_target.sv
`timescale 1ns/1ns
`default_nettype none
module pm_i2c_target #(
    parameter logic [7:0] SET_VERSION = 8'h5a, // Arbitrary value
    parameter int TICK = pm_regs_pkg::TICK_CYCLES,
    parameter int PULSE_HALF = pm_regs_pkg::PULSE_HALF_CYCLES,
    parameter int FLASH_HALF = pm_regs_pkg::FLASH_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] host_state,
    input wire logic switch_pressed,
    input wire logic touch_detected,
    input wire logic nv_load_en,
    input wire logic [7:0] nv_load_ptr,
    input wire logic [7:0] nv_load_data,
    output logic nv_store_strobe,
    output logic [7:0] nv_store_ptr,
    output logic [7:0] nv_store_data,
    output logic power_lamp,
    output logic [7:0] sense_charge_cycle_count,
    output logic host_off_request
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_TX_ACK
    } link_state_t;

    link_state_t state, next_state;
    logic scl_meta, scl_sync, scl_prev;
    logic sda_meta, sda_sync, sda_prev;
    logic [7:0] shift, next_shift;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [1:0] byte_idx, next_byte_idx;
    logic [7:0] ptr, next_ptr;
    logic reading, next_reading;
    logic ack_ok, next_ack_ok;
    logic master_ack, next_master_ack;
    logic next_sda_oe;
    logic [7:0] shadow_ptr, next_shadow_ptr;
    logic [7:0] shadow_data, next_shadow_data;
    logic shadow_full, next_shadow_full;
    logic [6:0] bus_target_address, next_bus_target_address;
    logic [7:0] power_lamp_mode, next_power_lamp_mode;
    logic [7:0] next_sense_charge_cycle_count;
    logic next_nv_store_strobe;
    logic [7:0] next_nv_store_ptr, next_nv_store_data;
    logic [3:0] history;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    function automatic logic writable(input logic [7:0] p);
        writable = (p == pm_regs_pkg::PTR_BUS_TARGET_ADDRESS) ||
                   (p == pm_regs_pkg::PTR_POWER_LAMP_MODE) ||
                   (p == pm_regs_pkg::PTR_SENSE_CHARGE_CYCLE_COUNT);
    endfunction

    // Every mapped writable register is one byte wide, so a shadow slot is
    // complete as soon as its byte lands; wider registers would extend this.
    function automatic logic last_byte_of_reg(input logic [7:0] p);
        last_byte_of_reg = writable(p);
    endfunction

    function automatic logic [7:0] read_byte(input logic [7:0] p);
        case (p)
            pm_regs_pkg::PTR_REGISTER_SET_VERSION: read_byte = SET_VERSION;
            pm_regs_pkg::PTR_BUS_TARGET_ADDRESS: read_byte = {1'b0, bus_target_address};
            pm_regs_pkg::PTR_POWER_LAMP_MODE: read_byte = power_lamp_mode;
            pm_regs_pkg::PTR_SENSE_CHARGE_CYCLE_COUNT: read_byte = sense_charge_cycle_count;
            pm_regs_pkg::PTR_BUTTON_SAMPLE_HISTORY: read_byte = {4'h0, history};
            default: read_byte = pm_regs_pkg::READ_FILL;
        endcase
    endfunction

    assign scl_rise = scl_sync && !scl_prev;
    assign scl_fall = !scl_sync && scl_prev;
    assign start_cond = scl_sync && scl_prev && sda_prev && !sda_sync;
    assign stop_cond = scl_sync && scl_prev && !sda_prev && sda_sync;

    // Bus protocol
    always_comb begin
        next_state = state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_byte_idx = byte_idx;
        next_ptr = ptr;
        next_reading = reading;
        next_ack_ok = ack_ok;
        next_master_ack = master_ack;
        next_sda_oe = sda_oe;
        next_shadow_ptr = shadow_ptr;
        next_shadow_data = shadow_data;
        next_shadow_full = 1'b0;
        if (start_cond) begin
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_byte_idx = 2'h0;
            next_sda_oe = 1'b0;
        end else if (stop_cond) begin
            // A register left half written simply never reaches the commit
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_RX: begin
                    if (scl_rise && bit_cnt < 4'h8) begin
                        next_shift = {shift[6:0], sda_sync};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        next_bit_cnt = 4'h0;
                        next_state = ST_ACK;
                        next_ack_ok = 1'b1;
                        if (state == ST_ADDR) begin
                            next_ack_ok = (shift[7:1] == bus_target_address);
                            next_reading = shift[0];
                        end else if (byte_idx == 2'h0) begin
                            next_ptr = shift;
                            next_byte_idx = 2'h1;
                        end else if (byte_idx == 2'h1) begin
                            next_ack_ok = (shift == ({bus_target_address, 1'b0} ^
                                           pm_regs_pkg::UNLOCK_XOR ^ ptr));
                            next_byte_idx = 2'h2;
                        end else if (writable(ptr)) begin
                            next_shadow_ptr = ptr;
                            next_shadow_data = shift;
                            next_shadow_full = last_byte_of_reg(ptr);
                            next_ptr = ptr + 8'h1;
                        end else begin
                            next_ack_ok = 1'b0;
                        end
                        next_sda_oe = next_ack_ok;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        if (!ack_ok) begin
                            next_state = ST_IDLE;
                        end else if (reading) begin
                            next_state = ST_TX;
                            next_shift = read_byte(ptr);
                            next_ptr = ptr + 8'h1;
                            next_sda_oe = !next_shift[7];
                            next_bit_cnt = 4'h1;
                        end else begin
                            next_state = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            next_sda_oe = 1'b0;
                            next_state = ST_TX_ACK;
                        end else begin
                            next_sda_oe = !shift[3'(4'h7 - bit_cnt)];
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        next_master_ack = !sda_sync;
                    end else if (scl_fall) begin
                        if (master_ack) begin
                            next_state = ST_TX;
                            next_shift = read_byte(ptr);
                            next_ptr = ptr + 8'h1;
                            next_sda_oe = !next_shift[7];
                            next_bit_cnt = 4'h1;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    // Register file, committed from the shadow one cycle after a full byte
    always_comb begin
        next_bus_target_address = bus_target_address;
        next_power_lamp_mode = power_lamp_mode;
        next_sense_charge_cycle_count = sense_charge_cycle_count;
        next_nv_store_strobe = 1'b0;
        next_nv_store_ptr = nv_store_ptr;
        next_nv_store_data = nv_store_data;
        if (shadow_full) begin
            case (shadow_ptr)
                pm_regs_pkg::PTR_BUS_TARGET_ADDRESS: next_bus_target_address = shadow_data[6:0];
                pm_regs_pkg::PTR_POWER_LAMP_MODE: next_power_lamp_mode = shadow_data;
                pm_regs_pkg::PTR_SENSE_CHARGE_CYCLE_COUNT: next_sense_charge_cycle_count = shadow_data;
                default: next_power_lamp_mode = power_lamp_mode;
            endcase
            next_nv_store_strobe = 1'b1;
            next_nv_store_ptr = shadow_ptr;
            next_nv_store_data = shadow_data;
            if (shadow_ptr == pm_regs_pkg::PTR_BUS_TARGET_ADDRESS) begin
                // Only seven address bits exist, so only those are saved
                next_nv_store_data = {1'b0, shadow_data[6:0]};
            end
        end else if (nv_load_en) begin
            // Restoring saved values after power-up
            case (nv_load_ptr)
                pm_regs_pkg::PTR_BUS_TARGET_ADDRESS: next_bus_target_address = nv_load_data[6:0];
                pm_regs_pkg::PTR_POWER_LAMP_MODE: next_power_lamp_mode = nv_load_data;
                pm_regs_pkg::PTR_SENSE_CHARGE_CYCLE_COUNT: next_sense_charge_cycle_count = nv_load_data;
                default: next_power_lamp_mode = power_lamp_mode;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            ptr <= 8'h00;
            reading <= 1'b0;
            ack_ok <= 1'b0;
            master_ack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            shadow_ptr <= 8'h00;
            shadow_data <= 8'h00;
            shadow_full <= 1'b0;
        end else begin
            scl_meta <= scl;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
            state <= next_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            byte_idx <= next_byte_idx;
            ptr <= next_ptr;
            reading <= next_reading;
            ack_ok <= next_ack_ok;
            master_ack <= next_master_ack;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
            shadow_ptr <= next_shadow_ptr;
            shadow_data <= next_shadow_data;
            shadow_full <= next_shadow_full;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_target_address <= pm_regs_pkg::RESET_BUS_TARGET_ADDRESS;
            power_lamp_mode <= pm_regs_pkg::RESET_POWER_LAMP_MODE;
            sense_charge_cycle_count <= pm_regs_pkg::RESET_SENSE_CHARGE_CYCLE_COUNT;
            nv_store_strobe <= 1'b0;
            nv_store_ptr <= 8'h00;
            nv_store_data <= 8'h00;
        end else begin
            bus_target_address <= next_bus_target_address;
            power_lamp_mode <= next_power_lamp_mode;
            sense_charge_cycle_count <= next_sense_charge_cycle_count;
            nv_store_strobe <= next_nv_store_strobe;
            nv_store_ptr <= next_nv_store_ptr;
            nv_store_data <= next_nv_store_data;
        end
    end

    lamp_driver #(
        .PULSE_HALF(PULSE_HALF),
        .FLASH_HALF(FLASH_HALF)
    ) u_lamp (
        .clk(clk),
        .rst(rst),
        .power_lamp_mode(power_lamp_mode),
        .host_state(host_state),
        .power_lamp(power_lamp)
    );

    button_sampler #(
        .TICK(TICK),
        .HOLD_TICKS(pm_regs_pkg::HOLD_OFF_TICKS)
    ) u_button (
        .clk(clk),
        .rst(rst),
        .switch_pressed(switch_pressed),
        .touch_detected(touch_detected),
        .sense_charge_cycle_count(sense_charge_cycle_count),
        .history(history),
        .off_request(host_off_request)
    );
endmodule // pm_i2c_target
`default_nettype wire

// file: core/pm_regs_pkg.sv
package pm_regs_pkg;
    localparam logic [7:0] PTR_REGISTER_SET_VERSION = 8'h00;
    localparam logic [7:0] PTR_BUS_TARGET_ADDRESS = 8'h01;
    localparam logic [7:0] PTR_POWER_LAMP_MODE = 8'h02;
    localparam logic [7:0] PTR_SENSE_CHARGE_CYCLE_COUNT = 8'h03;
    localparam logic [7:0] PTR_BUTTON_SAMPLE_HISTORY = 8'h3a;

    localparam logic [6:0] RESET_BUS_TARGET_ADDRESS = 7'h43;
    localparam logic [7:0] RESET_POWER_LAMP_MODE = 8'h01;
    localparam logic [7:0] RESET_SENSE_CHARGE_CYCLE_COUNT = 8'h00;
    localparam logic [7:0] UNLOCK_XOR = 8'hc9;
    localparam logic [7:0] READ_FILL = 8'hff;

    localparam logic [1:0] LAMP_OFF = 2'h0;
    localparam logic [1:0] LAMP_ON = 2'h1;
    localparam logic [1:0] LAMP_PULSE = 2'h2;
    localparam logic [1:0] LAMP_FLASH = 2'h3;

    localparam logic [1:0] HOST_OFF = 2'h0;
    localparam logic [1:0] HOST_BOOTING = 2'h1;
    localparam logic [1:0] HOST_ON = 2'h2;
    localparam logic [1:0] HOST_SHUTTING_DOWN = 2'h3;

    localparam int CLK_HZ = 10000000;
    localparam int TICK_MS = 50;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int HOLD_OFF_MS = 2000;
    localparam int HOLD_OFF_TICKS = HOLD_OFF_MS / TICK_MS;
    localparam int PULSE_HALF_MS = 500;
    localparam int PULSE_HALF_CYCLES = CLK_HZ / 1000 * PULSE_HALF_MS;
    localparam int FLASH_HALF_MS = 100;
    localparam int FLASH_HALF_CYCLES = CLK_HZ / 1000 * FLASH_HALF_MS;
endpackage

// file: core/lamp_driver.sv
`timescale 1ns/1ns
`default_nettype none
module lamp_driver #(
    parameter int PULSE_HALF = pm_regs_pkg::PULSE_HALF_CYCLES,
    parameter int FLASH_HALF = pm_regs_pkg::FLASH_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] power_lamp_mode,
    input wire logic [1:0] host_state,
    output logic power_lamp
);
    logic [23:0] pulse_cnt, next_pulse_cnt;
    logic [23:0] flash_cnt, next_flash_cnt;
    logic pulse_ph, next_pulse_ph;
    logic flash_ph, next_flash_ph;
    logic next_power_lamp;

    always_comb begin
        next_pulse_cnt = pulse_cnt + 24'h1;
        next_pulse_ph = pulse_ph;
        if (pulse_cnt >= 24'(PULSE_HALF - 1)) begin
            next_pulse_cnt = 24'h0;
            next_pulse_ph = ~pulse_ph;
        end
        next_flash_cnt = flash_cnt + 24'h1;
        next_flash_ph = flash_ph;
        if (flash_cnt >= 24'(FLASH_HALF - 1)) begin
            next_flash_cnt = 24'h0;
            next_flash_ph = ~flash_ph;
        end
        // The device owns the lamp outside the on state
        case (host_state)
            pm_regs_pkg::HOST_OFF: next_power_lamp = 1'b0;
            pm_regs_pkg::HOST_ON: begin
                case (power_lamp_mode[1:0])
                    pm_regs_pkg::LAMP_OFF: next_power_lamp = 1'b0;
                    pm_regs_pkg::LAMP_ON: next_power_lamp = 1'b1;
                    pm_regs_pkg::LAMP_PULSE: next_power_lamp = pulse_ph;
                    default: next_power_lamp = flash_ph;
                endcase
            end
            default: next_power_lamp = pulse_ph;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_cnt <= 24'h0;
            flash_cnt <= 24'h0;
            pulse_ph <= 1'b0;
            flash_ph <= 1'b0;
            power_lamp <= 1'b0;
        end else begin
            pulse_cnt <= next_pulse_cnt;
            flash_cnt <= next_flash_cnt;
            pulse_ph <= next_pulse_ph;
            flash_ph <= next_flash_ph;
            power_lamp <= next_power_lamp;
        end
    end
endmodule // lamp_driver
`default_nettype wire

// file: core/button_sampler.sv
`timescale 1ns/1ns
`default_nettype none
module button_sampler #(
    parameter int TICK = pm_regs_pkg::TICK_CYCLES,
    parameter int HOLD_TICKS = pm_regs_pkg::HOLD_OFF_TICKS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic switch_pressed,
    input wire logic touch_detected,
    input wire logic [7:0] sense_charge_cycle_count,
    output logic [3:0] history,
    output logic off_request
);
    logic sw_meta, sw_sync, tp_meta, tp_sync;
    logic [23:0] tick_cnt, next_tick_cnt;
    logic [3:0] next_history;
    logic [15:0] hold_cnt, next_hold_cnt;
    logic next_off_request;
    logic sample;

    always_comb begin
        // Zero count keeps the mechanical switch, nonzero selects touch
        sample = (sense_charge_cycle_count == 8'h00) ? sw_sync : tp_sync;
        next_tick_cnt = tick_cnt + 24'h1;
        next_history = history;
        next_hold_cnt = hold_cnt;
        next_off_request = 1'b0;
        if (tick_cnt >= 24'(TICK - 1)) begin
            next_tick_cnt = 24'h0;
            next_history = {history[2:0], sample};
            if (!sample) begin
                next_hold_cnt = 16'h0;
            end else if (hold_cnt != 16'hffff) begin
                next_hold_cnt = hold_cnt + 16'h1;
            end
            // One request per hold; short presses are left to software
            next_off_request = sample && (hold_cnt == 16'(HOLD_TICKS - 1));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sw_meta <= 1'b0;
            sw_sync <= 1'b0;
            tp_meta <= 1'b0;
            tp_sync <= 1'b0;
            tick_cnt <= 24'h0;
            history <= 4'h0;
            hold_cnt <= 16'h0;
            off_request <= 1'b0;
        end else begin
            sw_meta <= switch_pressed;
            sw_sync <= sw_meta;
            tp_meta <= touch_detected;
            tp_sync <= tp_meta;
            tick_cnt <= next_tick_cnt;
            history <= next_history;
            hold_cnt <= next_hold_cnt;
            off_request <= next_off_request;
        end
    end
endmodule // button_sampler
`default_nettype wire

// file: sim/pm_port_chk.sv
`timescale 1ns/1ns
`default_nettype none
module pm_port_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [1:0] host_state,
    input wire logic nv_load_en,
    input wire logic nv_store_strobe,
    input wire logic [7:0] nv_store_ptr,
    input wire logic [7:0] nv_store_data,
    input wire logic power_lamp,
    input wire logic [7:0] sense_charge_cycle_count,
    input wire logic host_off_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_drain_only: assert property (!sda_out)
        else $error("sda_out driven high");
    // The target may only move its data line while the bus clock is low
    a_oe_stands: assert property (scl && $past(scl) |-> $stable(sda_oe))
        else $error("sda_oe moved during scl high");
    a_lamp_off: assert property (host_state == pm_regs_pkg::HOST_OFF [*3] |=> !power_lamp)
        else $error("lamp lit while host off");
    a_store_pulse: assert property (nv_store_strobe |=> !nv_store_strobe)
        else $error("store strobe longer than one cycle");
    a_off_pulse: assert property (host_off_request |=> !host_off_request)
        else $error("off request longer than one cycle");
    a_store_ptr: assert property (nv_store_strobe |-> nv_store_ptr inside {8'h01, 8'h02, 8'h03})
        else $error("commit to unwritable pointer");
    a_addr_bit7: assert property (nv_store_strobe && nv_store_ptr == 8'h01 |-> !nv_store_data[7])
        else $error("address commit wider than seven bits");
    a_count_commit: assert property (nv_store_strobe && nv_store_ptr == 8'h03 |->
        sense_charge_cycle_count == nv_store_data)
        else $error("cycle count differs from commit");
    a_count_cause: assert property ($changed(sense_charge_cycle_count) |->
        nv_store_strobe || $past(nv_load_en))
        else $error("cycle count changed without commit");
endmodule // pm_port_chk
`default_nettype wire

// file: sim/i2c_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model #(
    parameter int HALF = 5003
) (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Just under 100 kHz; the odd half period drifts against the system clock
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic send_bit(input logic b);
        #(HALF / 4) sda_low = !b;
        #(HALF - HALF / 4) scl = 1'b1;
        #HALF scl = 1'b0;
    endtask
    task automatic take_bit(output logic b);
        sda_low = 1'b0;
        #HALF scl = 1'b1;
        #HALF b = sda;
        scl = 1'b0;
    endtask
    task automatic start_cond();
        sda_low = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_low = 1'b1;
        #HALF scl = 1'b0;
    endtask
    task automatic stop_cond();
        #(HALF / 4) sda_low = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_low = 1'b0;
        #HALF;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) send_bit(d[i]);
        take_bit(b);
        ack = !b;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) take_bit(d[i]);
        send_bit(last);
    endtask
endmodule // i2c_host_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
    localparam logic [7:0] VER = 8'h3c; // Arbitrary
    logic clk, rst, scl, sda_low, sda_out, sda_oe, sw, tc, ld, st, lamp_out, off, a;
    logic [1:0] hs;
    logic [7:0] lp, lv, sp, sv, cnt, r;
    logic [7:0] m [256];
    logic [6:0] adr, old;
    logic [15:0] g, w, got[$], want[$];
    int n_errors, total_checks, n_off;
    wire sda = !(sda_oe || sda_low);
    pm_i2c_target #(.SET_VERSION(VER), .TICK(20), .PULSE_HALF(16), .FLASH_HALF(4)) DUT (.clk(clk), .rst(rst),
        .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .host_state(hs), .switch_pressed(sw),
        .touch_detected(tc), .nv_load_en(ld), .nv_load_ptr(lp), .nv_load_data(lv), .nv_store_strobe(st),
        .nv_store_ptr(sp), .nv_store_data(sv), .power_lamp(lamp_out), .sense_charge_cycle_count(cnt),
        .host_off_request(off));
    i2c_host_model h (.scl(scl), .sda_low(sda_low), .sda(sda));
    function automatic logic [7:0] ul(input logic [7:0] p);
        return {adr, 1'b0} ^ pm_regs_pkg::UNLOCK_XOR ^ p;
    endfunction
    task automatic put(input logic [7:0] p, input logic [7:0] u, input logic [7:0] q[$]);
        logic ok;
        h.start_cond();
        h.put_byte({adr, 1'b0}, a);
        `CHK(a, 1'b1)
        h.put_byte(p, a);
        `CHK(a, 1'b1)
        ok = (u == ul(p));
        h.put_byte(u, a);
        `CHK(a, ok)
        foreach (q[i]) if (ok) begin
            ok = p inside {8'h01, 8'h02, 8'h03};
            h.put_byte(q[i], a);
            `CHK(a, ok)
            if (ok) begin
                m[p] = (p == 8'h01) ? {1'b0, q[i][6:0]} : q[i];
                want.push_back({p, m[p]});
                p++;
            end
        end
        h.stop_cond();
        repeat (8) @(posedge clk);
        while (want.size() > 0) begin
            g = got.pop_front();
            w = want.pop_front();
            `CHK(g, w)
        end
        `CHK(got.size(), 0)
    endtask
    task automatic get(input logic [7:0] p, input int n);
        logic [7:0] d;
        h.start_cond();
        h.put_byte({adr, 1'b0}, a);
        h.put_byte(p, a);
        h.stop_cond();
        h.start_cond();
        h.put_byte({adr, 1'b1}, a);
        `CHK(a, 1'b1)
        for (int i = 0; i < n; i++) begin
            h.get_byte(i == n - 1, d);
            `CHK(d, m[p])
            p++;
        end
        h.stop_cond();
    endtask
    task automatic load(input logic [7:0] p, input logic [7:0] d);
        @(posedge clk) #2 {ld, lp, lv} = {1'b1, p, d};
        @(posedge clk) #2 ld = 1'b0;
        m[p] = d;
    endtask
    task automatic btn(input logic s, input logic t);
        @(posedge clk) #2 {sw, tc} = {s, t};
        repeat (120) @(posedge clk);
    endtask
    task automatic lamp(input logic [1:0] s, input logic [7:0] md, input int half, input logic lvl);
        int tg;
        logic pv;
        load(8'h02, md);
        @(posedge clk) #2 hs = s;
        repeat (40) @(negedge clk);
        pv = lamp_out;
        tg = 0;
        repeat (64) begin
            @(negedge clk);
            tg += int'(lamp_out !== pv);
            pv = lamp_out;
        end
        if (half == 0) `CHK({tg == 0, lamp_out}, {1'b1, lvl})
        else `CHK(tg >= 64 / half - 1 && tg <= 64 / half + 1, 1'b1)
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(negedge clk) begin
        if (st === 1'b1) got.push_back({sp, sv});
        if (off === 1'b1) n_off++;
    end
    initial begin
        #9_000_000;
        n_errors++;
        wrap_up();
    end
    initial begin
        {rst, hs, sw, tc, ld, lp, lv} = {1'b1, 21'h0};
        void'($urandom(53967));
        adr = pm_regs_pkg::RESET_BUS_TARGET_ADDRESS;
        m = '{default: 8'hff};
        m[0] = VER;
        m[1] = {1'b0, adr};
        m[2] = pm_regs_pkg::RESET_POWER_LAMP_MODE;
        m[3] = pm_regs_pkg::RESET_SENSE_CHARGE_CYCLE_COUNT;
        m[8'h3a] = 8'h00;
        repeat (20) @(posedge clk);
        #2 rst = 1'b0;
        repeat (5) @(posedge clk);
        get(8'h00, 4);
        put(8'h02, ul(8'h02), '{8'h03, 8'h14});
        put(8'h02, ul(8'h02) ^ 8'h01, '{8'h00});
        get(8'h01, 3);
        `CHK(cnt, m[3])
        r = 8'h01 + 8'($urandom % 255);
        put(8'h03, ul(8'h03), '{r, 8'h55});
        get(8'h03, 2);
        put(8'h00, ul(8'h00), '{8'h12});
        r = {1'($urandom), 7'h10 + 7'($urandom % 80)};
        if (r[6:0] == adr) r++;
        put(8'h01, ul(8'h01), '{r});
        old = adr;
        adr = r[6:0];
        h.start_cond();
        h.put_byte({old, 1'b0}, a);
        `CHK(a, 1'b0)
        h.stop_cond();
        get(8'h01, 1);
        lamp(2'h0, 8'h01, 0, 1'b0);
        lamp(2'h1, 8'h01, 16, 1'b0);
        lamp(2'h3, 8'h01, 16, 1'b0);
        lamp(2'h2, 8'h00, 0, 1'b0);
        lamp(2'h2, 8'h01, 0, 1'b1);
        lamp(2'h2, 8'h02, 16, 1'b0);
        lamp(2'h2, 8'h03, 4, 1'b0);
        load(8'h03, 8'h00);
        btn(1'b1, 1'b0);
        repeat (480) @(posedge clk);
        btn(1'b0, 1'b0);
        `CHK(n_off, 0)
        btn(1'b1, 1'b0);
        m[8'h3a] = 8'h0f;
        get(8'h3a, 1);
        `CHK(n_off, 1)
        btn(1'b0, 1'b0);
        m[8'h3a] = 8'h00;
        get(8'h3a, 1);
        load(8'h03, 8'h14);
        `CHK(cnt, 8'h14)
        btn(1'b1, 1'b0);
        get(8'h3a, 1);
        btn(1'b0, 1'b1);
        m[8'h3a] = 8'h0f;
        get(8'h3a, 1);
        wrap_up();
    end
endmodule // tb
bind pm_i2c_target pm_port_chk u_chk (.clk(clk), .rst(rst), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
    .host_state(host_state), .nv_load_en(nv_load_en), .nv_store_strobe(nv_store_strobe),
    .nv_store_ptr(nv_store_ptr), .nv_store_data(nv_store_data), .power_lamp(power_lamp),
    .sense_charge_cycle_count(sense_charge_cycle_count), .host_off_request(host_off_request));
`default_nettype wire
